// ### src/cbs_pkg.sv
// shared constants and types of the cpu bus-cycle sequencer
package cbs_pkg;

  // ==========================================================
  // widths and fixed addresses
  localparam int CBS_AW = 16;
  localparam int CBS_DW = 8;
  localparam int CBS_STEP_W = 3;
  localparam logic [15:0] CBS_DUMMY_ADDR = 16'hFFFF;
  localparam logic [15:0] CBS_ADDR_STEP = 16'h0001;
  localparam logic [15:0] CBS_RESET_PC = 16'h0000;
  localparam logic [7:0] CBS_DIRECT_PAGE = 8'h00;
  localparam logic [7:0] CBS_PAGE_BASE = 8'h00;
  localparam logic [7:0] CBS_PAGE_Y = 8'h18;
  localparam logic [7:0] CBS_PAGE_D = 8'h1A;
  localparam logic CBS_RW_READ = 1'b1;
  localparam logic CBS_RW_WRITE = 1'b0;

  // ==========================================================
  // opcodes handled one by one
  localparam logic [7:0] CBS_OP_CALL_DIR = 8'h9D;
  localparam logic [7:0] CBS_OP_LDY_IMM = 8'hEC;
  localparam logic [7:0] CBS_OP_LDY_DIR = 8'hDE;
  localparam logic [7:0] CBS_OP_STY_DIR = 8'hDF;
  localparam logic [7:0] CBS_OP_CPY_IMM = 8'h8C;
  localparam logic [7:0] CBS_OP_CPY_DIR = 8'h9C;
  localparam logic [7:0] CBS_OP_CPD_IMM = 8'h83;
  localparam logic [7:0] CBS_OP_CPD_DIR = 8'h93;
  localparam logic [7:0] CBS_OP_BRANCH_IF_BITS_SET = 8'h12;
  localparam logic [7:0] CBS_OP_BRANCH_IF_BITS_CLEAR = 8'h13;
  localparam logic [7:0] CBS_OP_SET_BITS_IN_MEMORY = 8'h14;
  localparam logic [7:0] CBS_OP_CLEAR_BITS_IN_MEMORY = 8'h15;

  // ==========================================================
  // base page rows (high nibble) and columns (low nibble)
  localparam logic [3:0] CBS_ROW_IMM_A = 4'h8;
  localparam logic [3:0] CBS_ROW_DIR_A = 4'h9;
  localparam logic [3:0] CBS_ROW_IMM_B = 4'hC;
  localparam logic [3:0] CBS_ROW_DIR_B = 4'hD;
  localparam logic [3:0] CBS_COL_WARITH = 4'h3;
  localparam logic [3:0] CBS_COL_STORE8 = 4'h7;
  localparam logic [3:0] CBS_COL_WCMP = 4'hC;
  localparam logic [3:0] CBS_COL_CALLSTD = 4'hD;
  localparam logic [3:0] CBS_COL_WLOAD = 4'hE;
  localparam logic [3:0] CBS_COL_WSTORE = 4'hF;

  // ==========================================================
  // enumerations
  typedef enum logic [3:0] {
    G_NONE, G_IMM8, G_IMM16, G_IMM16W, G_DIR8, G_DST8, G_DIR16,
    G_DST16, G_DIR16W, G_CALL, G_BITOP, G_BRBIT
  } cbs_grp_t;

  typedef enum logic [2:0] {
    SEL_A, SEL_B, SEL_D, SEL_S, SEL_X, SEL_Y
  } cbs_sel_t;

  typedef enum logic [3:0] {
    K_FETCH, K_STREAM, K_EA, K_EA1, K_DUMMY, K_WR_EA, K_WR_EA1,
    K_WR_SP, K_WR_SP1
  } cbs_kind_t;

  typedef enum logic [3:0] {
    R_OPCODE, R_OPND, R_OPND_HI, R_OPND_LO, R_ADDR_LO, R_SUB_OP,
    R_MASK, R_OFFSET, R_IRREL, R_WRITE
  } cbs_role_t;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic [7:0] acc_first;
    logic [7:0] acc_second;
    logic [15:0] sp;
    logic [15:0] ix;
    logic [15:0] iy;
  } cbs_regs_t;

  typedef struct packed {
    logic [15:0] addr;
    logic rw;
    logic [7:0] dout;
    cbs_role_t role;
    logic sync;
  } cbs_bus_t;

  typedef struct packed {
    cbs_grp_t grp;
    cbs_sel_t sel;
    logic inv;
  } cbs_dec_t;

  typedef struct packed {
    cbs_kind_t kind;
    logic last;
  } cbs_step_t;

endpackage : cbs_pkg

// ### src/cbs_opclass.sv
// opcode classifier: instruction group and register of one opcode
`timescale 1ns/10ps
module cbs_opclass import cbs_pkg::*; (
  // opcode page and byte
  input wire logic [7:0] page,
  input wire logic [7:0] op,
  // classification
  output cbs_dec_t dec
);

  logic [3:0] row;
  logic [3:0] col;
  logic dir;
  logic side_b;

  // ==========================================================
  // decode
  always_comb begin
    row = op[7:4];
    col = op[3:0];
    dir = (row == CBS_ROW_DIR_A) || (row == CBS_ROW_DIR_B);
    side_b = (row == CBS_ROW_IMM_B) || (row == CBS_ROW_DIR_B);
    dec = '{grp: G_NONE, sel: SEL_A, inv: 1'b0};
    if (page == CBS_PAGE_Y) begin
      if (op == CBS_OP_CPY_IMM) begin
        dec = '{grp: G_IMM16W, sel: SEL_Y, inv: 1'b0};
      end else if (op == CBS_OP_CPY_DIR) begin
        dec = '{grp: G_DIR16W, sel: SEL_Y, inv: 1'b0};
      end else if (op == CBS_OP_LDY_IMM) begin
        dec = '{grp: G_IMM16, sel: SEL_Y, inv: 1'b0};
      end else if (op == CBS_OP_LDY_DIR) begin
        dec = '{grp: G_DIR16, sel: SEL_Y, inv: 1'b0};
      end else if (op == CBS_OP_STY_DIR) begin
        dec = '{grp: G_DST16, sel: SEL_Y, inv: 1'b0};
      end
    end else if (page == CBS_PAGE_D) begin
      if (op == CBS_OP_CPD_IMM) begin
        dec = '{grp: G_IMM16W, sel: SEL_D, inv: 1'b0};
      end else if (op == CBS_OP_CPD_DIR) begin
        dec = '{grp: G_DIR16W, sel: SEL_D, inv: 1'b0};
      end
    end else if (page == CBS_PAGE_BASE) begin
      if (op == CBS_OP_BRANCH_IF_BITS_SET) begin
        dec = '{grp: G_BRBIT, sel: SEL_A, inv: 1'b1};
      end else if (op == CBS_OP_BRANCH_IF_BITS_CLEAR) begin
        dec = '{grp: G_BRBIT, sel: SEL_A, inv: 1'b0};
      end else if (op == CBS_OP_SET_BITS_IN_MEMORY) begin
        dec = '{grp: G_BITOP, sel: SEL_A, inv: 1'b1};
      end else if (op == CBS_OP_CLEAR_BITS_IN_MEMORY) begin
        dec = '{grp: G_BITOP, sel: SEL_A, inv: 1'b0};
      end else if (op == CBS_OP_CALL_DIR) begin
        dec = '{grp: G_CALL, sel: SEL_A, inv: 1'b0};
      end else if (row == CBS_ROW_IMM_A || row == CBS_ROW_DIR_A ||
                   row == CBS_ROW_IMM_B || row == CBS_ROW_DIR_B) begin
        case (col)
          CBS_COL_WARITH: begin
            dec.grp = dir ? G_DIR16W : G_IMM16W;
            dec.sel = SEL_D;
          end
          CBS_COL_STORE8: begin
            dec.grp = dir ? G_DST8 : G_NONE;
            dec.sel = side_b ? SEL_B : SEL_A;
          end
          CBS_COL_WCMP: begin
            if (side_b) begin
              dec.grp = dir ? G_DIR16 : G_IMM16;
              dec.sel = SEL_D;
            end else begin
              dec.grp = dir ? G_DIR16W : G_IMM16W;
              dec.sel = SEL_X;
            end
          end
          CBS_COL_CALLSTD: begin
            dec.grp = (dir && side_b) ? G_DST16 : G_NONE;
            dec.sel = SEL_D;
          end
          CBS_COL_WLOAD: begin
            dec.grp = dir ? G_DIR16 : G_IMM16;
            dec.sel = side_b ? SEL_X : SEL_S;
          end
          CBS_COL_WSTORE: begin
            dec.grp = dir ? G_DST16 : G_NONE;
            dec.sel = side_b ? SEL_X : SEL_S;
          end
          default: begin
            dec.grp = dir ? G_DIR8 : G_IMM8;
            dec.sel = side_b ? SEL_B : SEL_A;
          end
        endcase
      end
    end
  end

endmodule : cbs_opclass

// ### src/cbs_sequencer.sv
// bus-cycle sequencer for immediate and direct mode instructions
`timescale 1ns/10ps
// Function
// - immediate 8-bit op: opcode, operand
// - immediate 16-bit load: opcode, high, low
// - immediate 16-bit arith: plus dummy read
// - immediate index y load: four reads
// - immediate wide compare paged: five cycles
// - direct address high byte is zero
// - direct 8-bit op: opcode, address, data
// - direct 8-bit store: third cycle writes
// - direct 16-bit load: data high, low
// - direct 16-bit store: two writes
// - direct index y load: five reads
// - direct index y store: three reads, two writes
// - direct 16-bit arith: plus dummy read
// - direct call: target read, push return
// - direct wide compare paged: six reads
// - bit set/clear: read, mask, dummy, write
// - bit branch: mask, offset, dummy, no write
module cbs_sequencer import cbs_pkg::*; #(
  parameter logic [15:0] RESET_PC = CBS_RESET_PC
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // read data and core registers
  input wire logic [7:0] rd_data,
  input wire cbs_regs_t core_regs,
  // bus cycle
  output cbs_bus_t cpu_bus
);

  // ==========================================================
  // state
  typedef struct packed {
    cbs_kind_t kind;
    logic [CBS_STEP_W-1:0] step;
    cbs_grp_t grp;
    cbs_sel_t sel;
    logic inv;
    logic [7:0] page;
    logic [15:0] fp;
    logic [15:0] ea;
    logic [7:0] opnd;
    logic [7:0] mask;
    logic [7:0] offs;
    cbs_bus_t bus;
  } cbs_state_t;

  // reset state is already the first opcode fetch
  localparam cbs_state_t RST_STATE = '{
    kind: K_FETCH, step: '0, grp: G_NONE, sel: SEL_A, inv: 1'b0,
    page: CBS_PAGE_BASE, fp: RESET_PC, ea: '0, opnd: '0, mask: '0,
    offs: '0,
    bus: '{addr: RESET_PC, rw: CBS_RW_READ, dout: '0, role: R_OPCODE,
           sync: 1'b1}
  };

  cbs_state_t state_r;
  cbs_state_t state_nxt;
  cbs_dec_t dec;
  cbs_step_t cur_step;

  // ==========================================================
  // helpers
  function automatic cbs_step_t step_plan(input cbs_grp_t g,
                                          input logic [2:0] s);
    cbs_step_t p;
    p = '{kind: K_FETCH, last: 1'b1};
    case (g)
      G_IMM8: p = '{kind: K_STREAM, last: 1'b1};
      G_IMM16: p = '{kind: K_STREAM, last: (s != 3'h0)};
      G_IMM16W: begin
        if (s == 3'h2) begin
          p = '{kind: K_DUMMY, last: 1'b1};
        end else begin
          p = '{kind: K_STREAM, last: 1'b0};
        end
      end
      G_DIR8: begin
        if (s == 3'h0) begin
          p = '{kind: K_STREAM, last: 1'b0};
        end else begin
          p = '{kind: K_EA, last: 1'b1};
        end
      end
      G_DST8: begin
        if (s == 3'h0) begin
          p = '{kind: K_STREAM, last: 1'b0};
        end else begin
          p = '{kind: K_WR_EA, last: 1'b1};
        end
      end
      G_DIR16: begin
        case (s)
          3'h0: p = '{kind: K_STREAM, last: 1'b0};
          3'h1: p = '{kind: K_EA, last: 1'b0};
          default: p = '{kind: K_EA1, last: 1'b1};
        endcase
      end
      G_DST16: begin
        case (s)
          3'h0: p = '{kind: K_STREAM, last: 1'b0};
          3'h1: p = '{kind: K_WR_EA, last: 1'b0};
          default: p = '{kind: K_WR_EA1, last: 1'b1};
        endcase
      end
      G_DIR16W: begin
        case (s)
          3'h0: p = '{kind: K_STREAM, last: 1'b0};
          3'h1: p = '{kind: K_EA, last: 1'b0};
          3'h2: p = '{kind: K_EA1, last: 1'b0};
          default: p = '{kind: K_DUMMY, last: 1'b1};
        endcase
      end
      G_CALL: begin
        case (s)
          3'h0: p = '{kind: K_STREAM, last: 1'b0};
          3'h1: p = '{kind: K_EA, last: 1'b0};
          3'h2: p = '{kind: K_WR_SP, last: 1'b0};
          default: p = '{kind: K_WR_SP1, last: 1'b1};
        endcase
      end
      G_BITOP: begin
        case (s)
          3'h0: p = '{kind: K_STREAM, last: 1'b0};
          3'h1: p = '{kind: K_EA, last: 1'b0};
          3'h2: p = '{kind: K_STREAM, last: 1'b0};
          3'h3: p = '{kind: K_DUMMY, last: 1'b0};
          default: p = '{kind: K_WR_EA, last: 1'b1};
        endcase
      end
      G_BRBIT: begin
        case (s)
          3'h0: p = '{kind: K_STREAM, last: 1'b0};
          3'h1: p = '{kind: K_EA, last: 1'b0};
          3'h2: p = '{kind: K_STREAM, last: 1'b0};
          3'h3: p = '{kind: K_STREAM, last: 1'b0};
          default: p = '{kind: K_DUMMY, last: 1'b1};
        endcase
      end
      default: p = '{kind: K_FETCH, last: 1'b1};
    endcase
    return p;
  endfunction : step_plan

  function automatic logic is_imm(input cbs_grp_t g);
    return (g == G_IMM8) || (g == G_IMM16) || (g == G_IMM16W);
  endfunction : is_imm

  function automatic cbs_role_t role_of(input cbs_state_t st);
    cbs_role_t ro;
    ro = R_WRITE;
    case (st.kind)
      K_FETCH: ro = R_OPCODE;
      K_STREAM: begin
        if (st.grp == G_IMM8) begin
          ro = R_OPND;
        end else if (is_imm(st.grp)) begin
          ro = (st.step == 3'h0) ? R_OPND_HI : R_OPND_LO;
        end else if (st.step == 3'h0) begin
          ro = R_ADDR_LO;
        end else if (st.step == 3'h2) begin
          ro = R_MASK;
        end else begin
          ro = R_OFFSET;
        end
      end
      K_EA: begin
        if (st.grp == G_CALL) begin
          ro = R_SUB_OP;
        end else if (st.grp == G_DIR16 || st.grp == G_DIR16W) begin
          ro = R_OPND_HI;
        end else begin
          ro = R_OPND;
        end
      end
      K_EA1: ro = R_OPND_LO;
      K_DUMMY: ro = R_IRREL;
      default: ro = R_WRITE;
    endcase
    return ro;
  endfunction : role_of

  function automatic logic [15:0] reg_word(input cbs_sel_t sel,
                                           input cbs_regs_t rg);
    logic [15:0] w;
    case (sel)
      SEL_A: w = {CBS_DIRECT_PAGE, rg.acc_first};
      SEL_B: w = {CBS_DIRECT_PAGE, rg.acc_second};
      SEL_D: w = {rg.acc_first, rg.acc_second};
      SEL_S: w = rg.sp;
      SEL_X: w = rg.ix;
      default: w = rg.iy;
    endcase
    return w;
  endfunction : reg_word

  // bus drive for the cycle that the state describes
  function automatic cbs_bus_t drive(input cbs_state_t st,
                                     input cbs_regs_t rg);
    cbs_bus_t b;
    logic [15:0] w;
    w = reg_word(st.sel, rg);
    b.addr = st.fp;
    b.rw = CBS_RW_READ;
    b.dout = '0;
    b.role = role_of(st);
    // the second byte after a prefix is not an instruction start
    b.sync = (st.kind == K_FETCH) && (st.page == CBS_PAGE_BASE);
    case (st.kind)
      K_EA: b.addr = st.ea;
      K_EA1: b.addr = st.ea + CBS_ADDR_STEP;
      K_DUMMY: b.addr = CBS_DUMMY_ADDR;
      K_WR_EA: begin
        b.addr = st.ea;
        b.rw = CBS_RW_WRITE;
        if (st.grp == G_BITOP) begin
          b.dout = st.inv ? (st.opnd | st.mask) : (st.opnd & ~st.mask);
        end else if (st.grp == G_DST8) begin
          b.dout = w[7:0];
        end else begin
          b.dout = w[15:8];
        end
      end
      K_WR_EA1: begin
        b.addr = st.ea + CBS_ADDR_STEP;
        b.rw = CBS_RW_WRITE;
        b.dout = w[7:0];
      end
      // sp taken live; the core owns its update
      K_WR_SP: begin
        b.addr = rg.sp;
        b.rw = CBS_RW_WRITE;
        b.dout = st.fp[7:0];
      end
      K_WR_SP1: begin
        b.addr = rg.sp - CBS_ADDR_STEP;
        b.rw = CBS_RW_WRITE;
        b.dout = st.fp[15:8];
      end
      default: b.addr = st.fp;
    endcase
    return b;
  endfunction : drive

  // ==========================================================
  // opcode classifier
  // decodes the byte in flight, so no decode cycle is lost
  cbs_opclass u_opclass (
    .page(state_r.page),
    .op(rd_data),
    .dec(dec)
  );

  // ==========================================================
  // next state
  always_comb begin
    state_nxt = state_r;
    cur_step = step_plan(state_r.grp, state_r.step);
    if (state_r.kind == K_FETCH) begin
      state_nxt.fp = state_r.fp + CBS_ADDR_STEP;
      // prefix byte opens a second fetch
      if (state_r.page == CBS_PAGE_BASE &&
          (rd_data == CBS_PAGE_Y || rd_data == CBS_PAGE_D)) begin
        state_nxt.page = rd_data;
      end else begin
        state_nxt.grp = dec.grp;
        state_nxt.sel = dec.sel;
        state_nxt.inv = dec.inv;
        state_nxt.step = '0;
        state_nxt.kind = step_plan(dec.grp, '0).kind;
        if (dec.grp == G_NONE) begin
          state_nxt.page = CBS_PAGE_BASE;
        end
      end
    end else begin
      if (state_r.kind == K_STREAM) begin
        state_nxt.fp = state_r.fp + CBS_ADDR_STEP;
        if (state_r.step == 3'h0 && !is_imm(state_r.grp)) begin
          // zero page forms the operand address
          state_nxt.ea = {CBS_DIRECT_PAGE, rd_data};
        end
        if (state_r.step == 3'h2) begin
          state_nxt.mask = rd_data;
        end
        if (state_r.step == 3'h3) begin
          state_nxt.offs = rd_data;
        end
      end
      // operand kept for bit ops and bit branches
      if (state_r.kind == K_EA) begin
        state_nxt.opnd = rd_data;
      end
      if (cur_step.last) begin
        // straight into the next opcode fetch
        state_nxt.kind = K_FETCH;
        state_nxt.page = CBS_PAGE_BASE;
        if (state_r.grp == G_CALL) begin
          state_nxt.fp = state_r.ea;
        end else if (state_r.grp == G_BRBIT &&
                     (((state_r.inv ? ~state_r.opnd : state_r.opnd) &
                       state_r.mask) == '0)) begin
          state_nxt.fp = state_r.fp +
                         {{(CBS_AW-CBS_DW){state_r.offs[7]}},
                          state_r.offs};
        end
      end else begin
        state_nxt.step = state_r.step + 3'h1;
        state_nxt.kind = step_plan(state_r.grp, state_nxt.step).kind;
      end
    end
    // drive from the next state: outputs leave flops directly
    state_nxt.bus = drive(state_nxt, core_regs);
  end

  // ==========================================================
  // registers
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= RST_STATE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // no logic between the state flop and the bus
  assign cpu_bus = state_r.bus;

endmodule : cbs_sequencer

// ### dv/cbs_seq_assertions.sv
// concurrent checks on the sequencer ports
`timescale 1ns/10ps
module cbs_seq_chk import cbs_pkg::*; (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // sequencer inputs
  input wire logic [7:0] rd_data,
  input wire cbs_regs_t core_regs,
  // bus cycle
  input wire cbs_bus_t cpu_bus
);
  // ==========================================================
  // assertions
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);
  wire is_rd = (cpu_bus.rw == CBS_RW_READ);
  wire is_wr = (cpu_bus.rw == CBS_RW_WRITE);
  chk_dummy_ones: assert property (
    cpu_bus.role == R_IRREL |-> is_rd && cpu_bus.addr == CBS_DUMMY_ADDR)
    else $error("dummy cycle not a read of all ones");
  chk_direct_page: assert property (
    cpu_bus.role == R_ADDR_LO |=>
    cpu_bus.addr == {CBS_DIRECT_PAGE, $past(rd_data)})
    else $error("direct address not on page zero");
  chk_stream_next: assert property (
    cpu_bus.role == R_OPCODE |=>
    is_rd && cpu_bus.addr == $past(cpu_bus.addr) + CBS_ADDR_STEP)
    else $error("byte after opcode not read at next address");
  chk_wide_pair: assert property (
    cpu_bus.role == R_OPND_HI |=> cpu_bus.role == R_OPND_LO &&
    cpu_bus.addr == $past(cpu_bus.addr) + CBS_ADDR_STEP)
    else $error("low byte not read after high byte");
  // sp is taken live, so the first push follows the sp of the cycle before
  chk_call_push: assert property (
    cpu_bus.role == R_SUB_OP |=> is_wr &&
    cpu_bus.addr == $past(core_regs.sp) ##1 is_wr &&
    cpu_bus.addr == $past(cpu_bus.addr) - CBS_ADDR_STEP ##1 cpu_bus.sync)
    else $error("return address push out of place");
  chk_bitop_write: assert property (
    cpu_bus.role == R_MASK ##1 cpu_bus.role == R_IRREL |=>
    is_wr && cpu_bus.addr == $past(cpu_bus.addr, 3))
    else $error("bit result not written to operand");
  chk_branch_read: assert property (
    cpu_bus.role == R_OFFSET |->
    cpu_bus.addr == $past(cpu_bus.addr) + CBS_ADDR_STEP ##1
    cpu_bus.role == R_IRREL && is_rd ##1 cpu_bus.sync)
    else $error("bit branch tail wrong");
  chk_no_idle: assert property (
    cpu_bus.role == R_IRREL |=> cpu_bus.sync || is_wr)
    else $error("idle cycle after dummy read");
  chk_write_pair: assert property (
    is_wr [*2] |=> cpu_bus.sync)
    else $error("no fetch after paired write");
  cov_call: cover property (cpu_bus.role == R_SUB_OP ##3 cpu_bus.sync);
  cov_bitop: cover property (cpu_bus.role == R_MASK ##2 is_wr);
  cov_branch: cover property (cpu_bus.role == R_OFFSET);
endmodule : cbs_seq_chk

bind cbs_sequencer cbs_seq_chk cbs_seq_chk_i (
  .sys_clk(sys_clk),
  .nrst(nrst),
  .rd_data(rd_data),
  .core_regs(core_regs),
  .cpu_bus(cpu_bus)
);

// ### dv/cbs_mem_model.sv
// program and data memory answering the sequencer bus
`timescale 1ns/10ps
module cbs_mem_model import cbs_pkg::*; (
  // clock
  input wire logic sys_clk,
  // bus from the sequencer
  input wire cbs_bus_t cpu_bus,
  // read data
  output logic [7:0] rd_data
);
  logic [7:0] mem [0:65535];
  logic [7:0] last_r = 8'h00;
  initial begin
    for (int i = 0; i < 65536; i++) begin
      mem[i] = 8'(i) ^ 8'hA5;
    end
  end
  // in write cycles the line is released: toggle, never a stale byte
  assign rd_data = (cpu_bus.rw == CBS_RW_READ) ? mem[cpu_bus.addr] : ~last_r;
  always @(posedge sys_clk) begin
    if (cpu_bus.rw == CBS_RW_WRITE) begin
      mem[cpu_bus.addr] <= cpu_bus.dout;
    end
    last_r <= rd_data;
  end
endmodule : cbs_mem_model

// ### dv/tb_top.sv
// random and corner-case bench of the bus-cycle sequencer
`timescale 1ns/10ps
module tb_top import cbs_pkg::*; ();
  // ==========================================================
  // signals
  localparam logic [15:0] BOOT_PC = 16'h4000;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] rd_data;
  cbs_regs_t core_regs = '0;
  cbs_bus_t cpu_bus;
  int n_fail = 0;
  int checked = 0;
  int seed = 32'h2AA4;
  int k;
  logic [15:0] pc;
  logic [15:0] q_a [$];
  logic q_w [$];
  logic [7:0] q_d [$];
  cbs_role_t q_r [$];
  logic [3:0] cols [10] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'h6, 4'h8,
    4'h9, 4'hA, 4'hB};

  always #10 sys_clk = ~sys_clk;

  cbs_sequencer #(.RESET_PC(BOOT_PC)) cbs_sequencer_i (
    .sys_clk(sys_clk), .nrst(nrst), .rd_data(rd_data),
    .core_regs(core_regs), .cpu_bus(cpu_bus));
  cbs_mem_model cbs_mem_model_i (
    .sys_clk(sys_clk), .cpu_bus(cpu_bus), .rd_data(rd_data));

  // ==========================================================
  // helpers
  task automatic chk(input string what, input logic [15:0] e,
    input logic [15:0] g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  task automatic ex(input logic [15:0] a, input logic w, input logic [7:0] d,
    input cbs_role_t r);
    q_a.push_back(a);
    q_w.push_back(w);
    q_d.push_back(w == CBS_RW_READ ? 8'h00 : d);
    q_r.push_back(r);
  endtask : ex

  task automatic stream(input logic [7:0] b, input cbs_role_t r);
    cbs_mem_model_i.mem[pc + 16'(k)] = b;
    ex(pc + 16'(k), CBS_RW_READ, 8'h00, r);
    k++;
  endtask : stream

  function automatic logic [7:0] pick3(input logic [7:0] x, y, z,
    input int r);
    return (r % 3 == 0) ? x : (r % 3 == 1) ? y : z;
  endfunction : pick3

  // bytes are laid in during the opcode cycle, before they are fetched
  task automatic run_one(input int f);
    logic [7:0] op, pg, a, m, d0, o;
    logic [15:0] v, ea, nx, wv;
    logic [3:0] hi;
    logic tk;
    int j;
    pg = 8'h00;
    k = 0;
    j = 0;
    tk = 1'b0;
    v = 16'($random(seed));
    a = 8'($random(seed));
    m = 8'($random(seed));
    d0 = 8'($random(seed));
    o = 8'($random(seed));
    core_regs = {$random(seed), $random(seed)};
    if (v[2]) a = v[3] ? 8'hFF : 8'h00;
    if (16'({8'h00, a} - pc + 16'h0001) < 16'h0006) a = a ^ 8'h80;
    ea = {CBS_DIRECT_PAGE, a};
    cbs_mem_model_i.mem[ea] = d0;
    hi = v[4] ? 4'hC : 4'h8;
    hi[0] = (f == 5);
    case (f)
      0, 5: op = {hi, cols[v[11:8] % 10]};
      1: op = pick3(8'hCC, 8'hCE, 8'h8E, v);
      2: op = pick3(8'h83, 8'hC3, 8'h8C, v);
      3: op = CBS_OP_LDY_IMM;
      4: op = v[0] ? CBS_OP_CPY_IMM : CBS_OP_CPD_IMM;
      6: op = v[0] ? 8'h97 : 8'hD7;
      7: op = pick3(8'hDC, 8'hDE, 8'h9E, v);
      8: op = pick3(8'hDD, 8'h9F, 8'hDF, v);
      9: op = CBS_OP_LDY_DIR;
      10: op = CBS_OP_STY_DIR;
      11: op = pick3(8'h93, 8'hD3, 8'h9C, v);
      12: op = v[0] ? CBS_OP_CPY_DIR : CBS_OP_CPD_DIR;
      13: op = CBS_OP_CALL_DIR;
      14: op = v[0] ? CBS_OP_SET_BITS_IN_MEMORY : CBS_OP_CLEAR_BITS_IN_MEMORY;
      default: op = v[0] ? CBS_OP_BRANCH_IF_BITS_SET : CBS_OP_BRANCH_IF_BITS_CLEAR;
    endcase
    if (f inside {3, 4, 9, 10, 12}) begin
      pg = (op == CBS_OP_CPD_IMM || op == CBS_OP_CPD_DIR) ? CBS_PAGE_D
        : CBS_PAGE_Y;
      stream(pg, R_OPCODE);
    end
    stream(op, R_OPCODE);
    case (f)
      0: stream(d0, R_OPND);
      1, 3, 2, 4: begin
        stream(d0, R_OPND_HI);
        stream(m, R_OPND_LO);
        if (f == 2 || f == 4) ex(CBS_DUMMY_ADDR, CBS_RW_READ, 8'h00, R_IRREL);
      end
      6: begin
        stream(a, R_ADDR_LO);
        ex(ea, CBS_RW_WRITE, op[6] ? core_regs.acc_second
          : core_regs.acc_first, R_WRITE);
      end
      8, 10: begin
        wv = (f == 10) ? core_regs.iy : (op == 8'hDD) ?
          {core_regs.acc_first, core_regs.acc_second} :
          (op == 8'h9F) ? core_regs.sp : core_regs.ix;
        stream(a, R_ADDR_LO);
        ex(ea, CBS_RW_WRITE, wv[15:8], R_WRITE);
        ex(ea + 16'h0001, CBS_RW_WRITE, wv[7:0], R_WRITE);
      end
      13: begin
        wv = pc + 16'h0002;
        stream(a, R_ADDR_LO);
        ex(ea, CBS_RW_READ, 8'h00, R_SUB_OP);
        ex(core_regs.sp, CBS_RW_WRITE, wv[7:0], R_WRITE);
        ex(core_regs.sp - 16'h0001, CBS_RW_WRITE, wv[15:8], R_WRITE);
      end
      14, 15: begin
        if (f == 15 && v[1]) m = m & (op[0] ? ~d0 : d0);
        tk = (f == 15) && (((op[0] ? d0 : ~d0) & m) == 8'h00);
        stream(a, R_ADDR_LO);
        ex(ea, CBS_RW_READ, 8'h00, R_OPND);
        stream(m, R_MASK);
        if (f == 15) stream(o, R_OFFSET);
        ex(CBS_DUMMY_ADDR, CBS_RW_READ, 8'h00, R_IRREL);
        if (f == 14) ex(ea, CBS_RW_WRITE, op[0] ? d0 & ~m : d0 | m, R_WRITE);
      end
      default: begin
        stream(a, R_ADDR_LO);
        ex(ea, CBS_RW_READ, 8'h00, (f == 5) ? R_OPND : R_OPND_HI);
        if (f != 5) ex(ea + 16'h0001, CBS_RW_READ, 8'h00, R_OPND_LO);
        if (f >= 11) ex(CBS_DUMMY_ADDR, CBS_RW_READ, 8'h00, R_IRREL);
      end
    endcase
    nx = (f == 13) ? ea : pc + 16'(k);
    if (tk) nx = nx + {{8{o[7]}}, o};
    chk("sync", 16'h0001, 16'(cpu_bus.sync));
    while (q_a.size() > 0) begin
      chk("address", q_a[0], cpu_bus.addr);
      chk("direction", 16'(q_w[0]), 16'(cpu_bus.rw));
      chk("write data", 16'(q_d[0]), 16'(cpu_bus.dout));
      chk("role", 16'(q_r[0]), 16'(cpu_bus.role));
      if (j > 0) chk("later sync", 16'h0000, 16'(cpu_bus.sync));
      j++;
      q_a.delete(0);
      q_w.delete(0);
      q_d.delete(0);
      q_r.delete(0);
      @(negedge sys_clk);
    end
    pc = nx;
  endtask : run_one

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : finish_test

  // ==========================================================
  // sequence
  initial begin
    pc = BOOT_PC;
    repeat (12) @(negedge sys_clk);
    chk("reset address", BOOT_PC, cpu_bus.addr);
    nrst = 1'b1;
    for (int i = 0; i < 600; i++) begin
      if (i == 300) begin
        nrst = 1'b0;
        @(negedge sys_clk);
        chk("reset address", BOOT_PC, cpu_bus.addr);
        nrst = 1'b1;
        pc = BOOT_PC;
      end
      run_one(i < 32 ? i % 16 : {$random(seed)} % 16);
    end
    finish_test();
  end

  // about 3000 cycles expected; five times that means a hang
  initial begin
    #300000;
    n_fail++;
    $display("MISMATCH run time expected end seen hang");
    finish_test();
  end
endmodule : tb_top
